// ===== core/pmtb_time_base.sv
// Master time base with AHB-Lite register slave, counter, compare and interrupts.
//
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module pmtb_time_base (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic             o_irq,
  output logic             o_trigger,
  output logic             o_match,
  output logic [15:0]      o_counter
);

  typedef struct packed {
    pmtb_pkg::pmtb_cfg_t cfg;
    logic [15:0]         counter;
    logic [2:0]          status;
    logic [2:0]          irq_en;
    logic                irq;
    logic                trigger;
    logic                match;
    logic                ph_valid;
    logic                ph_write;
    logic [7:0]          ph_addr;
    logic [31:0]         rdata;
  } pmtb_state_t;

  pmtb_state_t state;
  pmtb_state_t next_state;
  logic [1:0]  rst_sync;
  logic        rst_n;
  logic        tick;
  logic        match_now;
  logic        trig_now;
  logic        wrap_now;
  logic [2:0]  events;
  logic [2:0]  clr_bits;
  logic        wr_now;

  // Reset is asserted asynchronously but is released only through two flip-flops.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  pmtb_prescaler u_prescaler (
    .i_clk     (i_clk),
    .i_rst_n   (rst_n),
    .i_run     (state.cfg.enable),
    .i_divider (state.cfg.divider),
    .o_tick    (tick)
  );

  pmtb_postscaler u_postscaler (
    .i_clk       (i_clk),
    .i_rst_n     (rst_n),
    .i_run       (state.cfg.enable),
    .i_match     (match_now),
    .i_postscale (state.cfg.postscale),
    .o_trigger   (trig_now)
  );

  // RULE12 counter equals compare
  assign match_now = tick && (state.counter == {state.cfg.compare, 3'h0});
  assign wrap_now  = tick && (state.counter >= state.cfg.period);
  assign events    = {wrap_now, match_now, trig_now};

  always_comb begin
    next_state = state;
    clr_bits = 3'h0;
    wr_now = state.ph_valid && state.ph_write;

    // Address phase is captured; the data phase always completes in one cycle.
    next_state.ph_valid = i_hsel && i_hready && i_htrans[1];
    next_state.ph_write = i_hwrite;
    next_state.ph_addr  = i_haddr[7:0];

    if (wr_now) begin
      unique case ({24'h0, state.ph_addr})
        pmtb_pkg::ADDR_CONTROL: begin
          next_state.cfg.enable    = i_hwdata[pmtb_pkg::CTRL_ENABLE_BIT];
          next_state.cfg.postscale = i_hwdata[3:0];
        end
        // RULE10 only divider field
        pmtb_pkg::ADDR_CLKDIV:  next_state.cfg.divider = i_hwdata[2:0];
        // RULE6 full period word
        pmtb_pkg::ADDR_PERIOD:  next_state.cfg.period = i_hwdata[15:0];
        // RULE9 low bits dropped
        pmtb_pkg::ADDR_COMPARE: next_state.cfg.compare = i_hwdata[15:pmtb_pkg::CMP_LSB];
        pmtb_pkg::ADDR_IRQ_EN:  next_state.irq_en = i_hwdata[2:0];
        pmtb_pkg::ADDR_IRQ_CLR: clr_bits = i_hwdata[2:0];
        default: ;
      endcase
    end

    // RULE11 count and wrap
    if (!state.cfg.enable) begin
      next_state.counter = 16'h0000;
    end else if (wrap_now) begin
      next_state.counter = 16'h0000;
    end else if (tick) begin
      next_state.counter = state.counter + 16'h0001;
    end

    // A new event in the clearing cycle wins over the clear.
    next_state.status  = (state.status & ~clr_bits) | events;
    next_state.irq     = |(next_state.status & next_state.irq_en);
    next_state.trigger = trig_now;
    next_state.match   = match_now;

    next_state.rdata = 32'h0000_0000;
    if (next_state.ph_valid && !i_hwrite) begin
      unique case ({24'h0, i_haddr[7:0]})
        pmtb_pkg::ADDR_CONTROL: begin
          next_state.rdata[pmtb_pkg::CTRL_ENABLE_BIT] = next_state.cfg.enable;
          next_state.rdata[3:0] = next_state.cfg.postscale;
        end
        pmtb_pkg::ADDR_CLKDIV:   next_state.rdata[2:0] = next_state.cfg.divider;
        pmtb_pkg::ADDR_PERIOD:   next_state.rdata[15:0] = next_state.cfg.period;
        // RULE8 compare in upper bits
        pmtb_pkg::ADDR_COMPARE:  next_state.rdata[15:0] = {next_state.cfg.compare, 3'h0};
        pmtb_pkg::ADDR_COUNTER:  next_state.rdata[15:0] = next_state.counter;
        pmtb_pkg::ADDR_IRQ_STAT: next_state.rdata[2:0] = next_state.status;
        pmtb_pkg::ADDR_IRQ_EN:   next_state.rdata[2:0] = next_state.irq_en;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state                <= '0;
      state.cfg.period     <= pmtb_pkg::PERIOD_RESET;
      state.cfg.divider    <= pmtb_pkg::DIV_RESET;
      state.cfg.postscale  <= pmtb_pkg::PS_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign o_hrdata    = state.rdata;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_irq       = state.irq;
  assign o_trigger   = state.trigger;
  assign o_match     = state.match;
  assign o_counter   = state.counter;

endmodule

// ===== include/pmtb_pkg.sv
// Package with register map, field layout, reset values and shared types of the time base.
// How it works
// RULE1: Postscale code N emits one trigger every N+1 compare matches.
// RULE2: Software changes postscale and marked settings only while the module is disabled.
// RULE3: With external sync, software sets period slightly above the sync period.
// RULE4: Divider codes 000 to 110 divide by 1 to 64; 111 reserved; reset 000.
// RULE5: Software never changes the divider while the time base runs.
// RULE6: A 16-bit writable master period value sets the counter period.
// RULE7: Software keeps the master period between 0x0010 and 0xFFF8.
// RULE8: Compare value is 13 bits held in bits 15 down to 3.
// RULE9: Compare register bits 2 to 0 read zero and ignore writes.
// RULE10: Divider register bits 15 to 3 read zero; only divider field writes.
// RULE11: Enabled counter advances per divided clock, wraps to zero at period.
// RULE12: Counter equal to compare value is a match; postscaler counts matches.
package pmtb_pkg;

  localparam logic [31:0] ADDR_CONTROL   = 32'h0000_0000;
  localparam logic [31:0] ADDR_CLKDIV    = 32'h0000_0004;
  localparam logic [31:0] ADDR_PERIOD    = 32'h0000_0008;
  localparam logic [31:0] ADDR_COMPARE   = 32'h0000_000C;
  localparam logic [31:0] ADDR_COUNTER   = 32'h0000_0010;
  localparam logic [31:0] ADDR_IRQ_STAT  = 32'h0000_0014;
  localparam logic [31:0] ADDR_IRQ_EN    = 32'h0000_0018;
  localparam logic [31:0] ADDR_IRQ_CLR   = 32'h0000_001C;

  localparam int          CTRL_ENABLE_BIT = 15;
  localparam int          CMP_LSB         = 3;
  localparam logic [15:0] PERIOD_RESET    = 16'hFFF8;
  localparam logic [2:0]  DIV_RESET       = 3'h0;
  localparam logic [2:0]  DIV_RESERVED    = 3'h7;
  localparam logic [3:0]  PS_RESET        = 4'h0;

  // Status bit 0: trigger emitted; bit 1: compare match; bit 2: period wrap.
  localparam int          NUM_EVENTS = 3;

  typedef struct packed {
    logic        enable;
    logic [3:0]  postscale;
    logic [2:0]  divider;
    logic [15:0] period;
    logic [12:0] compare;
  } pmtb_cfg_t;

  typedef struct packed {
    logic trigger;
    logic match;
    logic wrap;
  } pmtb_evt_t;

endpackage

// ===== core/pmtb_prescaler.sv
// Input clock prescaler producing a one-cycle tick per divided clock.
`timescale 1ns/1ps
module pmtb_prescaler (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_run,
  input  wire logic [2:0] i_divider,
  output logic            o_tick
);

  typedef struct packed {
    logic [5:0] count;
  } pmtb_pre_state_t;

  pmtb_pre_state_t state;
  pmtb_pre_state_t next_state;
  logic [5:0]      limit;

  always_comb begin
    // RULE4 divide by power
    limit = 6'(({6'h0, 1'b1} << i_divider) - 7'h1);
    next_state = state;
    o_tick = 1'b0;
    if (!i_run || i_divider == pmtb_pkg::DIV_RESERVED) begin
      next_state.count = 6'h00;
    end else if (state.count >= limit) begin
      next_state.count = 6'h00;
      o_tick = 1'b1;
    end else begin
      next_state.count = state.count + 6'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

endmodule

// ===== core/pmtb_postscaler.sv
// Postscaler turning compare matches into special event trigger pulses.
`timescale 1ns/1ps
module pmtb_postscaler (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_run,
  input  wire logic       i_match,
  input  wire logic [3:0] i_postscale,
  output logic            o_trigger
);

  typedef struct packed {
    logic [3:0] count;
  } pmtb_post_state_t;

  pmtb_post_state_t state;
  pmtb_post_state_t next_state;

  always_comb begin
    next_state = state;
    o_trigger = 1'b0;
    if (!i_run) begin
      next_state.count = 4'h0;
    end else if (i_match) begin
      // RULE1 one per N+1
      if (state.count >= i_postscale) begin
        next_state.count = 4'h0;
        o_trigger = 1'b1;
      end else begin
        next_state.count = state.count + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

endmodule

// ===== dv/pmtb_time_base_asserts.sv
// Checker of the time base port behaviour.
`timescale 1ns/1ps
module pmtb_time_base_asserts (
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic        o_irq,
  input wire logic        o_trigger,
  input wire logic        o_match,
  input wire logic [15:0] o_counter
);
  wire logic rd_take = i_hsel & i_hready & i_htrans[1] & ~i_hwrite;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_resp_okay: assert property (o_hreadyout && !o_hresp)
    else $error("bus response not OKAY");
  a_count_step: assert property ($changed(o_counter) |->
    o_counter == $past(o_counter) + 16'h1 || o_counter == 16'h0) else $error("counter jumped");
  a_match_once: assert property (o_match |=> !o_match) else $error("match too long");
  a_trig_match: assert property (o_trigger |-> o_match) else $error("trigger without match");
  a_match_low: assert property (o_match |-> $past(o_counter[2:0]) == 3'h0)
    else $error("match off compare grid");
  a_upper_zero: assert property (o_hrdata[31:16] == 16'h0) else $error("upper data set");
  a_div_bits: assert property ($past(rd_take && i_haddr == pmtb_pkg::ADDR_CLKDIV) |->
    o_hrdata[31:3] == 29'h0) else $error("divider high bits set");
  a_cmp_bits: assert property ($past(rd_take && i_haddr == pmtb_pkg::ADDR_COMPARE) |->
    o_hrdata[2:0] == 3'h0) else $error("compare low bits set");
  c_trigger: cover property (o_trigger);
  c_irq: cover property (o_irq);
  c_match: cover property (o_match);
endmodule
bind pmtb_time_base pmtb_time_base_asserts u_chk (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
  .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_irq(o_irq), .o_trigger(o_trigger), .o_match(o_match), .o_counter(o_counter));

// ===== dv/pmtb_time_base_tb.sv
// Self-checking testbench of the master time base.
`timescale 1ns/1ps
module pmtb_time_base_tb;
  logic        i_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hready;
  logic        irq;
  logic        trig;
  logic        match;
  logic [15:0] counter;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          n;
  always #5 i_clk = ~i_clk;
  pmtb_time_base dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(),
    .o_irq(irq), .o_trigger(trig), .o_match(match), .o_counter(counter));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge i_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge i_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Waits for a trigger or a match pulse and returns the cycles spent.
  task automatic gap(input logic t);
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while ((t ? trig : match) !== 1'b1 && n < 3000);
  endtask
  task automatic t_reset;
    rchk(pmtb_pkg::ADDR_PERIOD, 32'h0000_FFF8);
    rchk(pmtb_pkg::ADDR_CLKDIV, 32'h0);
    rchk(pmtb_pkg::ADDR_COMPARE, 32'h0);
    rchk(pmtb_pkg::ADDR_CONTROL, 32'h0);
  endtask
  task automatic t_regs;
    xfer(1'b1, pmtb_pkg::ADDR_PERIOD, 32'h0000_1235);
    rchk(pmtb_pkg::ADDR_PERIOD, 32'h0000_1235);
    xfer(1'b1, pmtb_pkg::ADDR_COMPARE, 32'hFFFF_FFFF);
    rchk(pmtb_pkg::ADDR_COMPARE, 32'h0000_FFF8);
    xfer(1'b1, pmtb_pkg::ADDR_CLKDIV, 32'hFFFF_FFFF);
    rchk(pmtb_pkg::ADDR_CLKDIV, 32'h7);
    rchk(32'h0000_0020, 32'h0);
    xfer(1'b1, pmtb_pkg::ADDR_CONTROL, 32'h0000_8000);
    // Long enough that even a divide-by-64 tick would move the counter.
    repeat (200) @(posedge i_clk);
    chk({16'h0, counter}, 32'h0);
    xfer(1'b1, pmtb_pkg::ADDR_CONTROL, 32'h0);
  endtask
  task automatic t_div;
    xfer(1'b1, pmtb_pkg::ADDR_PERIOD, 32'h0000_0010);
    xfer(1'b1, pmtb_pkg::ADDR_COMPARE, 32'h0000_0008);
    for (int d = 0; d < 7; d++) begin
      xfer(1'b1, pmtb_pkg::ADDR_CLKDIV, 32'(d));
      xfer(1'b1, pmtb_pkg::ADDR_CONTROL, 32'h0000_8000);
      gap(1'b0);
      gap(1'b0);
      chk(32'(n), 32'(17 << d));
      xfer(1'b1, pmtb_pkg::ADDR_CONTROL, 32'h0);
    end
    xfer(1'b1, pmtb_pkg::ADDR_CLKDIV, 32'h0);
  endtask
  task automatic t_post;
    int ps;
    int m;
    for (int i = 0; i < 3; i++) begin
      ps = (i == 2) ? 15 : i;
      xfer(1'b1, pmtb_pkg::ADDR_CONTROL, 32'h0000_8000 | 32'(ps));
      gap(1'b1);
      m = 0;
      do begin
        @(posedge i_clk);
        if (match === 1'b1) m++;
      end while (trig !== 1'b1 && m < 40);
      chk(32'(m), 32'(ps + 1));
      xfer(1'b1, pmtb_pkg::ADDR_CONTROL, 32'h0);
    end
  endtask
  task automatic t_irq;
    // Earlier scenarios leave status bits set; start from a clean status.
    xfer(1'b1, pmtb_pkg::ADDR_IRQ_CLR, 32'h7);
    rchk(pmtb_pkg::ADDR_IRQ_STAT, 32'h0);
    xfer(1'b1, pmtb_pkg::ADDR_IRQ_EN, 32'h1);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, pmtb_pkg::ADDR_CONTROL, 32'h0000_8000);
    gap(1'b1);
    xfer(1'b1, pmtb_pkg::ADDR_CONTROL, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rchk(pmtb_pkg::ADDR_IRQ_STAT, 32'h3);
    rchk(pmtb_pkg::ADDR_COUNTER, 32'h0);
    xfer(1'b1, pmtb_pkg::ADDR_CONTROL, 32'h0000_8000);
    gap(1'b1);
    gap(1'b1);
    xfer(1'b1, pmtb_pkg::ADDR_CONTROL, 32'h0);
    rchk(pmtb_pkg::ADDR_IRQ_STAT, 32'h7);
    xfer(1'b1, pmtb_pkg::ADDR_IRQ_EN, 32'h0);
    repeat (2) @(posedge i_clk);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, pmtb_pkg::ADDR_IRQ_CLR, 32'h7);
    xfer(1'b1, pmtb_pkg::ADDR_IRQ_EN, 32'h7);
    repeat (2) @(posedge i_clk);
    chk({31'h0, irq}, 32'h0);
    rchk(pmtb_pkg::ADDR_IRQ_STAT, 32'h0);
  endtask
  task automatic report_and_stop;
    $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // A hung handshake or a silent counter ends the run here.
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 50000) begin
      n_mismatch++;
      report_and_stop;
    end
  end
  initial begin
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clk);
    t_reset;
    t_regs;
    t_div;
    t_post;
    t_irq;
    report_and_stop;
  end
endmodule
